//--- ugr_pkg.sv
// Package for the user glyph RAM lookup: widths, field positions and carriers
package ugr_pkg;
  // ****************************************
  // Sizes
  // ****************************************
  localparam int unsigned UGR_ADDR_W     = 6;
  localparam int unsigned UGR_DEPTH      = 64;
  localparam int unsigned UGR_DOT_W      = 5;
  localparam int unsigned UGR_ROW_W      = 3;
  // ****************************************
  // Field positions and values
  // ****************************************
  localparam logic [2:0] UGR_CURSOR_ROW  = 3'h7;
  localparam logic [3:0] UGR_USER_HIGH   = 4'h0;
  localparam logic [7:0] UGR_BYTE_RESET  = 8'h00;
  localparam logic [4:0] UGR_DOTS_DARK   = 5'h00;
  localparam logic [5:0] UGR_ADDR_RESET  = 6'h00;
  localparam logic [5:0] UGR_ADDR_STEP   = 6'h01;

  // Host access to the pattern store
  typedef struct packed {
    logic       set_addr;
    logic [5:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } ugr_host_s;

  // Refresh-side lookup request
  typedef struct packed {
    logic       valid;
    logic [7:0] code;
    logic [2:0] row;
    logic       cursor_on;
  } ugr_look_s;

  // Register state of the block; the pattern store is kept apart
  typedef struct packed {
    logic [5:0] address_pointer;
    logic [7:0] rdata;
    logic       rvalid;
    logic [4:0] dots;
    logic       user_sel;
    logic       dots_valid;
  } ugr_state_s;
endpackage

//--- ugr_lookup.sv
// User glyph RAM: host-written dot patterns looked up by the display refresh path
`timescale 1ns/1ns
`default_nettype none
// How it works
// RULE_01 - The 64-byte store holds eight 5x8 glyphs or four 5x10 glyphs, chosen by the tall-font input; lookups never reach rows nine and ten.
// RULE_02 - The low five bits of a stored byte form one dot row, bit 4 leftmost and bit 0 rightmost.
// RULE_03 - In 5x8 mode character code bits 0 to 2 become store address bits 3 to 5.
// RULE_04 - A one bit lights its dot and a zero bit leaves it dark.
// RULE_05 - Store address bits 0 to 2 pick the glyph row, counted from the top.
// RULE_06 - In 5x8 mode row eight is the cursor row and shows the stored row ORed with the cursor.
// RULE_07 - The host writes zeros into dot bits of row eight of every 5x8 glyph.
// RULE_08 - Any set dot bit in row eight stays lit whatever the cursor does.
// RULE_09 - A user glyph is chosen whenever code bits 4 to 7 are all zero.
// RULE_10 - Code bit 3 is ignored for user glyphs, so codes 00H and 08H look the same.
// RULE_11 - The host may rewrite any row at any time and later lookups show the new data.
// RULE_12 - In 5x10 mode code bits 1 and 2 become store address bits 4 and 5.
// RULE_13 - After every host read or write the address pointer steps by one, up or down per entry mode.
// RULE_14 - Data bits 5 to 7 never reach the dots, and the 64-entry store uses a 6-bit address.
module ugr_lookup
  import ugr_pkg::*;
(
  input  wire logic       clk_sys_i,
  input  wire logic       arst_n_i,
  input  wire ugr_host_s  host_i,
  input  wire logic       incr_mode_i,
  input  wire logic       tall_font_i,
  input  wire ugr_look_s  look_i,
  output logic [7:0]      host_rdata_o,
  output logic            host_rvalid_o,
  output logic [5:0]      address_pointer_o,
  output logic [4:0]      dots_o,
  output logic            user_sel_o,
  output logic            dots_valid_o
);

  // ****************************************
  // Reset image
  // ****************************************
  // Every flip-flop starts dark and idle; the pattern store keeps what it held
  localparam ugr_state_s UGR_STATE_RESET = '{
    address_pointer: UGR_ADDR_RESET,
    rdata:           UGR_BYTE_RESET,
    rvalid:          1'b0,
    dots:            UGR_DOTS_DARK,
    user_sel:        1'b0,
    dots_valid:      1'b0
  };

  // ****************************************
  // Pattern store
  // ****************************************
  // No reset on the array: contents are undefined until the host loads them
  logic [7:0]  user_glyph_ram [UGR_DEPTH];
  ugr_state_s  state_reg;
  ugr_state_s  state_next;

  logic        host_set;
  logic [5:0]  host_new_addr;
  logic        host_read;
  logic        host_write;
  logic        host_access;
  logic [7:0]  host_wdata;
  logic [5:0]  host_addr;
  logic [5:0]  host_addr_moved;
  logic [7:0]  host_byte;

  logic        look_valid;
  logic [7:0]  look_code;
  logic [2:0]  look_row;
  logic        look_cursor;
  logic [5:0]  look_addr;
  logic [7:0]  look_byte;
  logic [4:0]  look_stored;
  logic [4:0]  look_dots;
  logic        look_user;

  // ****************************************
  // Decoding helpers
  // ****************************************
  // Forms the store address from a character code and a row
  function automatic logic [5:0] glyph_addr(
    input logic [7:0] code,
    input logic [2:0] row,
    input logic       tall
  );
    logic [5:0] a;
    a = {code[2:0], row};  // RULE_03 RULE_05 RULE_10
    if (tall) begin
      // Rows nine and ten are out of reach of a three-bit row
      a = {code[2:1], 1'b0, row};  // RULE_12
    end
    return a;
  endfunction

  // Keeps only the dot field of a stored byte
  function automatic logic [4:0] row_dots(
    input logic [7:0] stored
  );
    logic [4:0] d;
    d = stored[UGR_DOT_W-1:0];  // RULE_02 RULE_04 RULE_14
    return d;
  endfunction

  // ORs the cursor into the last row of a short glyph
  function automatic logic [4:0] cursor_merge(
    input logic [4:0] dots,
    input logic [2:0] row,
    input logic       tall,
    input logic       cursor_on
  );
    logic [4:0] m;
    m = dots;
    if (!tall && row == UGR_CURSOR_ROW) begin
      // Stored dots stay lit whatever the cursor does, so the host keeps them zero
      m = dots | {UGR_DOT_W{cursor_on}};  // RULE_06 RULE_08
    end
    return m;
  endfunction

  // Upper four code bits all zero pick the user store
  function automatic logic is_user_code(
    input logic [7:0] code
  );
    logic hit;
    hit = (code[7:4] == UGR_USER_HIGH);  // RULE_09
    return hit;
  endfunction

  // Pointer moves by one either way and wraps within the store
  function automatic logic [5:0] step_pointer(
    input logic [5:0] addr,
    input logic       up
  );
    logic [5:0] n;
    n = addr - UGR_ADDR_STEP;
    if (up) begin
      n = addr + UGR_ADDR_STEP;
    end
    return n;
  endfunction

  // ****************************************
  // Host access
  // ****************************************
  assign host_set      = host_i.set_addr;
  assign host_new_addr = host_i.addr;
  assign host_read     = host_i.rd;
  assign host_write    = host_i.wr;
  assign host_wdata    = host_i.wdata;
  assign host_access   = host_read | host_write;
  // Set-address takes effect at once for an access in the same cycle
  assign host_addr       = host_set ? host_new_addr : state_reg.address_pointer;
  assign host_addr_moved = step_pointer(host_addr, incr_mode_i);  // RULE_13
  // A read in the same cycle as a write returns the old byte
  assign host_byte       = user_glyph_ram[host_addr];

  always_ff @(posedge clk_sys_i) begin
    if (host_write) begin
      user_glyph_ram[host_addr] <= host_wdata;  // RULE_11
    end
  end

  // ****************************************
  // Lookup path
  // ****************************************
  assign look_valid  = look_i.valid;
  assign look_code   = look_i.code;
  assign look_row    = look_i.row;
  assign look_cursor = look_i.cursor_on;
  assign look_addr   = glyph_addr(look_code, look_row, tall_font_i);  // RULE_01 RULE_14
  assign look_byte   = user_glyph_ram[look_addr];
  assign look_stored = row_dots(look_byte);
  assign look_dots   = cursor_merge(look_stored, look_row, tall_font_i, look_cursor);
  assign look_user   = is_user_code(look_code);

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    state_next        = state_reg;
    state_next.rvalid = 1'b0;
    if (host_read) begin
      state_next.rdata  = host_byte;
      state_next.rvalid = 1'b1;
    end
    // An access steps from the freshly loaded address when both come together
    case ({host_set, host_access})
      2'b01: begin
        state_next.address_pointer = host_addr_moved;  // RULE_13
      end
      2'b10: begin
        state_next.address_pointer = host_new_addr;
      end
      2'b11: begin
        state_next.address_pointer = host_addr_moved;  // RULE_13
      end
      default: begin
        state_next.address_pointer = state_reg.address_pointer;
      end
    endcase
    state_next.dots_valid = look_valid;
    if (look_valid) begin
      state_next.user_sel = look_user;  // RULE_09
      // The fixed font lies outside, so its codes leave these dots dark
      state_next.dots     = look_user ? look_dots : UGR_DOTS_DARK;
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg <= UGR_STATE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign host_rdata_o      = state_reg.rdata;
  assign host_rvalid_o     = state_reg.rvalid;
  assign address_pointer_o = state_reg.address_pointer;
  assign dots_o            = state_reg.dots;
  assign user_sel_o        = state_reg.user_sel;
  assign dots_valid_o      = state_reg.dots_valid;

endmodule
`default_nettype wire

//--- ugr_monitor.sv
// Port checker for the glyph lookup
`timescale 1ns/1ns
`default_nettype none
module ugr_monitor import ugr_pkg::*; (
  input wire logic       clk_sys_i,
  input wire logic       arst_n_i,
  input wire ugr_host_s  host_i,
  input wire logic       incr_mode_i,
  input wire ugr_look_s  look_i,
  input wire logic [5:0] address_pointer_o,
  input wire logic [4:0] dots_o,
  input wire logic       user_sel_o,
  input wire logic       dots_valid_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);
  a_ptr_up: assert property ((host_i.wr || host_i.rd) && !host_i.set_addr && incr_mode_i
    |=> address_pointer_o == $past(address_pointer_o) + 6'h01) else $error("pointer up");
  a_ptr_down: assert property ((host_i.wr || host_i.rd) && !host_i.set_addr && !incr_mode_i
    |=> address_pointer_o == $past(address_pointer_o) - 6'h01) else $error("pointer down");
  a_ptr_set: assert property (host_i.set_addr && host_i.wr && incr_mode_i
    |=> address_pointer_o == $past(host_i.addr) + 6'h01) else $error("pointer load");
  a_ptr_idle: assert property (!host_i.wr && !host_i.rd && !host_i.set_addr
    |=> $stable(address_pointer_o)) else $error("pointer moved");
  a_dot_answer: assert property (look_i.valid |=> dots_valid_o) else $error("no dots");
  a_dot_hold: assert property (!look_i.valid |=> !dots_valid_o && $stable(dots_o))
    else $error("dots moved");
  a_user_pick: assert property (look_i.valid && look_i.code[7:4] == 4'h0 |=> user_sel_o)
    else $error("user glyph missed");
  a_font_dark: assert property (look_i.valid && look_i.code[7:4] != 4'h0
    |=> !user_sel_o && dots_o == 5'h00) else $error("font code lit");
endmodule
`default_nettype wire

//--- ugr_host_model.sv
// Host model that loads and reads glyph rows
`timescale 1ns/1ns
`default_nettype none
module ugr_host_model import ugr_pkg::*; (
  input wire logic      clk_sys_i,
  output var ugr_host_s host_o
);
  initial host_o = '0;
  // Row 7 dots are cleared unless a scenario asks for a bad load
  task automatic acc(input logic s, input logic [5:0] a, input logic [7:0] d, input logic rd, input logic bad);
    @(posedge clk_sys_i) #1;
    host_o = '{s, a, !rd, rd, (bad || a[2:0] != 3'h7) ? d : d & 8'hE0};
    @(posedge clk_sys_i) #1;
    host_o = '0;
  endtask
endmodule
`default_nettype wire

//--- ugr_tb.sv
// Testbench for the glyph lookup
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin n_fail++; $display("unexpected %s %h %h", n, e, s); end end
module tb;
  import ugr_pkg::*;
  logic       clk_sys_i = 0, arst_n_i = 0, incr_mode_i = 1, tall_font_i = 0, rvalid, user_sel, dvalid;
  ugr_host_s  host;
  ugr_look_s  look_i = '0;
  logic [7:0] rdata;
  logic [5:0] ptr;
  logic [4:0] dots;
  int         n_fail = 0, n_checks = 0;
  always #25 clk_sys_i = ~clk_sys_i;
  ugr_host_model u_host (.clk_sys_i(clk_sys_i), .host_o(host));
  ugr_lookup u_dut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .host_i(host), .incr_mode_i(incr_mode_i),
    .tall_font_i(tall_font_i), .look_i(look_i), .host_rdata_o(rdata), .host_rvalid_o(rvalid),
    .address_pointer_o(ptr), .dots_o(dots), .user_sel_o(user_sel), .dots_valid_o(dvalid));
  task automatic look(input logic [7:0] c, input logic [2:0] r, input logic cur, input logic [4:0] e);
    @(posedge clk_sys_i) #1;
    look_i = '{1'b1, c, r, cur};
    @(posedge clk_sys_i) #1;
    look_i.valid = 0;
    `CHK("dots", e, dots)
    `CHK("user_sel", c[7:4] == 4'h0, user_sel)
    `CHK("dots_valid", 1'b1, dvalid)
  endtask
  task automatic s_glyphs;
    for (int i = 0; i < 56; i++) u_host.acc(1, 6'(i / 7 * 8 + i % 7), 8'(8'hE0 + i), 0, 0);
    for (int i = 0; i < 56; i++) look(8'({i[0], 3'(i / 7)}), 3'(i % 7), 1, 5'(i));
  endtask
  task automatic s_cursor;
    u_host.acc(1, 6'h17, 8'hFF, 0, 0);
    look(8'h02, 3'h7, 0, 5'h00);
    look(8'h0A, 3'h7, 1, 5'h1F);
    u_host.acc(1, 6'h17, 8'h0A, 0, 1);
    look(8'h02, 3'h7, 0, 5'h0A);
  endtask
  task automatic s_font;
    for (int k = 1; k < 16; k++) look({4'(k), 4'h0}, 3'h0, 1, 5'h00);
  endtask
  task automatic s_tall;
    tall_font_i = 1;
    look(8'h07, 3'h3, 0, 5'h0D);
    look(8'h03, 3'h7, 1, 5'h0A);
    tall_font_i = 0;
  endtask
  task automatic s_ptr;
    incr_mode_i = 0;
    u_host.acc(1, 6'h21, 8'h00, 1, 0);
    `CHK("rdata", 8'hFD, rdata)
    `CHK("rvalid", 1'b1, rvalid)
    `CHK("ptr", 6'h20, ptr)
    u_host.acc(0, 6'h20, 8'h00, 1, 0);
    `CHK("rdata", 8'hFC, rdata)
    incr_mode_i = 1;
    u_host.acc(0, 6'h1F, 8'h00, 0, 0);
    `CHK("ptr", 6'h20, ptr)
    `CHK("rvalid", 1'b0, rvalid)
    `CHK("rdata", 8'hFC, rdata)
    u_host.acc(1, 6'h3F, 8'h00, 0, 0);
    `CHK("ptr", 6'h00, ptr)
  endtask
  task automatic s_reset;
    u_host.acc(1, 6'h05, 8'hE5, 0, 0);
    @(posedge clk_sys_i) #1;
    arst_n_i = 0;
    #1;
    `CHK("rst_ptr", UGR_ADDR_RESET, ptr)
    `CHK("rst_rdata", UGR_BYTE_RESET, rdata)
    `CHK("rst_rvalid", 1'b0, rvalid)
    `CHK("rst_dots", UGR_DOTS_DARK, dots)
    `CHK("rst_user_sel", 1'b0, user_sel)
    `CHK("rst_dots_valid", 1'b0, dvalid)
    repeat (2) @(posedge clk_sys_i);
    #1 arst_n_i = 1;
    look(8'h0A, 3'h7, 0, 5'h0A);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk_sys_i);
    #1 arst_n_i = 1;
    s_glyphs;
    s_cursor;
    s_font;
    s_tall;
    s_ptr;
    s_reset;
    end_sim;
  end
  initial begin
    repeat (5000) @(posedge clk_sys_i);
    n_fail++;
    end_sim;
  end
endmodule
bind ugr_lookup ugr_monitor u_mon (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .host_i(host_i), .look_i(look_i),
  .incr_mode_i(incr_mode_i), .address_pointer_o(address_pointer_o), .dots_o(dots_o), .user_sel_o(user_sel_o),
  .dots_valid_o(dots_valid_o));
`default_nettype wire
